//--- hw/rfcl_consts.vh
/*
 * constants for the rf front end configuration latch bank: word layout,
 * latch select codes, field positions and timing figures.
 * assumes inclusion by bare name from the design file only.
 */
`ifndef RFCL_CONSTS_VH
`define RFCL_CONSTS_VH

// ==========================================================
// serial word
`define RFCL_WORD_W        24
`define RFCL_BITCNT_W      5

// ==========================================================
// latch select codes, low bits of the word
`define RFCL_SEL2_SYNTH    2'b10
`define RFCL_SEL2_RECV     2'b11
`define RFCL_SEL2_CTRL     2'b00
`define RFCL_SEL3_RXCAL    3'b101

// ==========================================================
// synthesizer loop word fields
`define RFCL_PRE_HI        23
`define RFCL_PRE_LO        22
`define RFCL_GAIN_BIT      21
`define RFCL_FBMUX_BIT     20
`define RFCL_BDIV_HI       19
`define RFCL_BDIV_LO       7
`define RFCL_ADIV_HI       6
`define RFCL_ADIV_LO       2

// ==========================================================
// receive word fields
`define RFCL_BOOST_BIT     7
`define RFCL_BW_HI         6
`define RFCL_BW_LO         5
`define RFCL_GAIN_HI       4
`define RFCL_GAIN_LO       2

// ==========================================================
// calibration word fields
`define RFCL_CALDIV_HI     14
`define RFCL_CALDIV_LO     9
`define RFCL_TMO_HI        8
`define RFCL_TMO_LO        3

// ==========================================================
// timing and gain step
`define RFCL_GAIN_STEP_DB  5'h03
`define RFCL_TMO_ZERO      6'h00
`define RFCL_ONE6          6'h01

// ==========================================================
// reset values
`define RFCL_BDIV_RST      13'h0003

`endif

//--- hw/rfcl_latch_bank.v
/*
 * configuration latch bank: three-wire serial shifter, word routing into
 * synthesizer, receive, calibration and control latches, and the boost
 * timeout timer.
 * assumes serial pins and divided reference are asynchronous to clk_i and
 * much slower than it (serial clock at most 12.5 mhz, clk_i at 50 mhz).
 * assumes each serial clock level and each data bit lasts two clk_i periods
 * or more, so that the two-stage synchronisers never miss an edge.
 * no reset exists at the pins; rst_n_i is the block's own power-on reset.
 */
// Notes on behaviour
// - boost lasts timeout value times divided reference periods, up to 63.
// - timeout zero means boost ends only when host clears the enable bit.
// - low select bits one-zero route the word to the synthesizer latch.
// - two-bit synthesizer field selects the prescaler value.
// - gain override zero uses programmed pump current, one forces maximum.
// - feedback mux zero feeds oscillator back, one feeds mux signal.
// - thirteen-bit b divider loaded from synthesizer latch; host keeps 3..8191.
// - five-bit a divider loaded from synthesizer latch, any value 0..31.
// - low select bits one-one route the word to the receive latch.
// - boost enable bit one activates high-pass boost, zero disables it.
// - two-bit receive field selects filter bandwidth.
// - three-bit gain code decodes to 3 db through 24 db in 3 db steps.
// - low three select bits one-zero-one route to calibration latch.
// - low select bits zero-zero route the word to the control latch.
`include "rfcl_consts.vh"

module rfcl_latch_bank (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        serial_clock_pin_i,
    input  wire        serial_data_pin_i,
    input  wire        load_strobe_pin_i,
    input  wire        cal_ref_clock_i,
    output reg  [1:0]  prescaler_select_o,
    output reg         pump_gain_override_o,
    output reg         feedback_mux_select_o,
    output reg  [12:0] b_divider_value_o,
    output reg  [4:0]  a_divider_value_o,
    output reg         boost_active_o,
    output reg  [1:0]  rx_bandwidth_select_o,
    output reg  [2:0]  rx_gain_code_o,
    output reg  [4:0]  rx_gain_db_o,
    output reg  [5:0]  cal_divider_value_o,
    output reg  [5:0]  boost_timeout_value_o,
    output reg  [23:0] control_word_o,
    output reg         control_load_o
);

    // ==========================================================
    // helpers
    function [4:0] gain_to_db;
        input [2:0] code;
        begin
            gain_to_db = ({2'b00, code} + 5'h01) * `RFCL_GAIN_STEP_DB;
        end
    endfunction

    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    function is_synth;
        input [2:0] bits;
        begin
            is_synth = (bits[1:0] == `RFCL_SEL2_SYNTH);
        end
    endfunction

    function is_recv;
        input [2:0] bits;
        begin
            is_recv = (bits[1:0] == `RFCL_SEL2_RECV);
        end
    endfunction

    function is_rxcal;
        input [2:0] bits;
        begin
            is_rxcal = (bits == `RFCL_SEL3_RXCAL);
        end
    endfunction

    function is_ctrl;
        input [2:0] bits;
        begin
            is_ctrl = (bits[1:0] == `RFCL_SEL2_CTRL);
        end
    endfunction

    function reached;
        input [5:0] count;
        input [5:0] limit;
        begin
            reached = (count >= limit);
        end
    endfunction

    // ==========================================================
    // synchronisers; first stage read only by second
    reg sclk_meta_ff;
    reg sclk_sync_ff;
    reg sclk_last_ff;
    reg sdat_meta_ff;
    reg sdat_sync_ff;
    reg load_meta_ff;
    reg load_sync_ff;
    reg load_last_ff;
    reg ref_meta_ff;
    reg ref_sync_ff;
    reg ref_last_ff;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_meta_ff <= 1'b0;
            sclk_sync_ff <= 1'b0;
            sclk_last_ff <= 1'b0;
            sdat_meta_ff <= 1'b0;
            sdat_sync_ff <= 1'b0;
            load_meta_ff <= 1'b0;
            load_sync_ff <= 1'b0;
            load_last_ff <= 1'b0;
            ref_meta_ff  <= 1'b0;
            ref_sync_ff  <= 1'b0;
            ref_last_ff  <= 1'b0;
        end else begin
            sclk_meta_ff <= serial_clock_pin_i;
            sclk_sync_ff <= sclk_meta_ff;
            sclk_last_ff <= sclk_sync_ff;
            sdat_meta_ff <= serial_data_pin_i;
            sdat_sync_ff <= sdat_meta_ff;
            load_meta_ff <= load_strobe_pin_i;
            load_sync_ff <= load_meta_ff;
            load_last_ff <= load_sync_ff;
            ref_meta_ff  <= cal_ref_clock_i;
            ref_sync_ff  <= ref_meta_ff;
            ref_last_ff  <= ref_sync_ff;
        end
    end

    wire sclk_rise = rise(sclk_sync_ff, sclk_last_ff);
    wire sdat      = sdat_sync_ff;
    wire load_rise = rise(load_sync_ff, load_last_ff);
    wire ref_rise  = rise(ref_sync_ff, ref_last_ff);

    // ==========================================================
    // shifter; data stays aligned with clock since both pass equal stages
    reg [23:0] shift_ff;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_ff <= 24'h000000;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[22:0], sdat};
        end
    end

    wire [2:0] sel         = shift_ff[2:0];
    wire       synth_write = load_rise & is_synth(sel);
    wire       recv_write  = load_rise & is_recv(sel);
    wire       cal_write   = load_rise & is_rxcal(sel);
    wire       ctrl_write  = load_rise & is_ctrl(sel);

    // ==========================================================
    // synthesizer loop latch
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescaler_select_o    <= 2'h0;
            pump_gain_override_o  <= 1'b0;
            feedback_mux_select_o <= 1'b0;
            b_divider_value_o     <= `RFCL_BDIV_RST;
            a_divider_value_o     <= 5'h00;
        end else if (synth_write) begin
            prescaler_select_o    <= shift_ff[`RFCL_PRE_HI:`RFCL_PRE_LO];
            pump_gain_override_o  <= shift_ff[`RFCL_GAIN_BIT];
            feedback_mux_select_o <= shift_ff[`RFCL_FBMUX_BIT];
            b_divider_value_o     <= shift_ff[`RFCL_BDIV_HI:`RFCL_BDIV_LO];
            a_divider_value_o     <= shift_ff[`RFCL_ADIV_HI:`RFCL_ADIV_LO];
        end
    end

    // ==========================================================
    // receive latch; boost enable feeds the timer below
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_bandwidth_select_o <= 2'h0;
            rx_gain_code_o        <= 3'h0;
            rx_gain_db_o          <= `RFCL_GAIN_STEP_DB;
        end else if (recv_write) begin
            rx_bandwidth_select_o <= shift_ff[`RFCL_BW_HI:`RFCL_BW_LO];
            rx_gain_code_o        <= shift_ff[`RFCL_GAIN_HI:`RFCL_GAIN_LO];
            rx_gain_db_o          <= gain_to_db(shift_ff[`RFCL_GAIN_HI:`RFCL_GAIN_LO]);
        end
    end

    // ==========================================================
    // calibration latch
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cal_divider_value_o   <= 6'h00;
            boost_timeout_value_o <= 6'h00;
        end else if (cal_write) begin
            cal_divider_value_o   <= shift_ff[`RFCL_CALDIV_HI:`RFCL_CALDIV_LO];
            boost_timeout_value_o <= shift_ff[`RFCL_TMO_HI:`RFCL_TMO_LO];
        end
    end

    // ==========================================================
    // control latch; transmit word (select 001) has no outputs in this bank
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_word_o <= 24'h000000;
            control_load_o <= 1'b0;
        end else begin
            control_load_o <= ctrl_write;
            if (ctrl_write) begin
                control_word_o <= shift_ff;
            end
        end
    end

    // ==========================================================
    // boost timer states
    // restarts on every receive write that sets the enable,
    // trading re-arm on redundant writes for a simpler trigger
    localparam [1:0] BST_IDLE   = 2'b00;
    localparam [1:0] BST_MANUAL = 2'b01;
    localparam [1:0] BST_TIMED  = 2'b10;

    wire       boost_set = recv_write & shift_ff[`RFCL_BOOST_BIT];
    wire       tmo_zero  = (boost_timeout_value_o == `RFCL_TMO_ZERO);
    reg  [1:0] state_ff;
    reg  [5:0] count_ff;
    reg  [1:0] nxt_state;
    reg  [5:0] nxt_count;
    reg        nxt_boost;

    // ==========================================================
    // boost timer next state
    always @* begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_boost = boost_active_o;

        if (recv_write) begin
            nxt_count = `RFCL_TMO_ZERO;
            nxt_boost = boost_set;
            if (!boost_set) begin
                nxt_state = BST_IDLE;
            end else if (tmo_zero) begin
                nxt_state = BST_MANUAL;
            end else begin
                nxt_state = BST_TIMED;
            end
        end else begin
            case (state_ff)
                BST_TIMED: begin
                    if (ref_rise) begin
                        nxt_count = count_ff + `RFCL_ONE6;
                        if (reached(nxt_count, boost_timeout_value_o)) begin
                            nxt_boost = 1'b0;
                            nxt_state = BST_IDLE;
                        end
                    end
                end
                BST_MANUAL: begin
                    nxt_boost = 1'b1;
                end
                default: begin
                    nxt_state = BST_IDLE;
                    nxt_boost = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // boost timer registers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boost_active_o <= 1'b0;
            state_ff       <= BST_IDLE;
            count_ff       <= 6'h00;
        end else begin
            boost_active_o <= nxt_boost;
            state_ff       <= nxt_state;
            count_ff       <= nxt_count;
        end
    end

endmodule

//--- test/rfcl_host_model.sv
/* host side of the three-wire write port.
   assumes clk_i is the bench clock; serial clock is 8 clk_i periods. */
module rfcl_host_model (
    input  logic clk_i,
    output logic sclk_o,
    output logic serial_data_pin_o,
    output logic sle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======== write port
    initial begin
        sclk_o = 1'b0;
        serial_data_pin_o = 1'b0;
        sle_o = 1'b0;
    end
    // clock idles low between words; 160 ns period stays under 20 mhz
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data_pin_o <= w[i]; // msb first
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        serial_data_pin_o <= ~w[0]; // no stale bit once released
        repeat (4) @(posedge clk_i);
        sle_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        sle_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

//--- test/rfcl_latch_bank_props.sv
/* checker for the configuration latch bank, bound onto its top.
   assumes each strobe stays high for several clk_i periods. */
module rfcl_latch_bank_props (
    input logic        clk_i,
    input logic        rst_n_i,
    input logic        load_strobe_pin_i,
    input logic        cal_ref_clock_i,
    input logic [1:0]  prescaler_select_o,
    input logic [12:0] b_divider_value_o,
    input logic [4:0]  a_divider_value_o,
    input logic        boost_active_o,
    input logic [1:0]  rx_bandwidth_select_o,
    input logic [2:0]  rx_gain_code_o,
    input logic [4:0]  rx_gain_db_o,
    input logic [5:0]  boost_timeout_value_o,
    input logic [23:0] control_word_o,
    input logic        control_load_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======== properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // latches move only a few clocks after a strobe
    sequence s_wr;
        $past(load_strobe_pin_i, 3);
    endsequence
    a_synth_on_write: assert property ($changed({prescaler_select_o,
        b_divider_value_o, a_divider_value_o}) |-> s_wr) else $error("synth moved");
    a_rx_on_write: assert property (
        $changed({rx_bandwidth_select_o, rx_gain_code_o}) |-> s_wr) else $error("rx moved");
    a_gain_decode: assert property (
        rx_gain_db_o == 5'(rx_gain_code_o) * 5'h03 + 5'h03) else $error("gain db wrong");
    a_ctrl_one_pulse: assert property (
        control_load_o |=> !control_load_o) else $error("load pulse too long");
    a_ctrl_on_write: assert property (
        $changed(control_word_o) |-> control_load_o ##0 s_wr) else $error("ctrl moved");
    a_boost_on_write: assert property (
        $rose(boost_active_o) |-> s_wr) else $error("boost rose");
    a_boost_zero_hold: assert property (
        $fell(boost_active_o) && $past(boost_timeout_value_o) == 6'h00 |-> s_wr)
        else $error("boost ended by itself");
    a_boost_ends_ref: assert property (
        $fell(boost_active_o) |-> $past(cal_ref_clock_i, 2) || $past(load_strobe_pin_i, 3))
        else $error("boost ended off ref");
endmodule

//--- test/rfcl_latch_bank_test.sv
/* directed writes to the latch bank with expected latch contents.
   assumes design, model and checker are compiled first. */
module rfcl_latch_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ======== signals
    logic        clk_i = 1'b0, rst_n_i = 1'b0, cal_ref_clock_i = 1'b0;
    logic        serial_clock_pin_i, serial_data_pin_i, load_strobe_pin_i;
    logic [1:0]  prescaler_select_o, rx_bandwidth_select_o;
    logic        pump_gain_override_o, feedback_mux_select_o, boost_active_o, control_load_o;
    logic [12:0] b_divider_value_o;
    logic [4:0]  a_divider_value_o, rx_gain_db_o;
    logic [2:0]  rx_gain_code_o;
    logic [5:0]  cal_divider_value_o, boost_timeout_value_o;
    logic [23:0] control_word_o;
    int          cyc = 0, blen = 0, bl0 = 0, cl_cnt = 0, fail_count = 0, n_tests = 0;
    rfcl_latch_bank rfcl_latch_bank_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .serial_clock_pin_i(serial_clock_pin_i), .serial_data_pin_i(serial_data_pin_i),
        .load_strobe_pin_i(load_strobe_pin_i), .cal_ref_clock_i(cal_ref_clock_i),
        .prescaler_select_o(prescaler_select_o), .pump_gain_override_o(pump_gain_override_o),
        .feedback_mux_select_o(feedback_mux_select_o), .b_divider_value_o(b_divider_value_o),
        .a_divider_value_o(a_divider_value_o), .boost_active_o(boost_active_o),
        .rx_bandwidth_select_o(rx_bandwidth_select_o), .rx_gain_code_o(rx_gain_code_o),
        .rx_gain_db_o(rx_gain_db_o), .cal_divider_value_o(cal_divider_value_o),
        .boost_timeout_value_o(boost_timeout_value_o), .control_word_o(control_word_o),
        .control_load_o(control_load_o));
    rfcl_host_model rfcl_host_model_i (.clk_i(clk_i), .sclk_o(serial_clock_pin_i),
        .serial_data_pin_o(serial_data_pin_i), .sle_o(load_strobe_pin_i));
    always #10 clk_i = ~clk_i;
    // ref near 2 mhz: 26 clk_i periods
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc % 13 == 12) cal_ref_clock_i <= ~cal_ref_clock_i;
        if (boost_active_o) blen <= blen + 1;
        if (control_load_o) cl_cnt <= cl_cnt + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [23:0] w);
        rfcl_host_model_i.send(w);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({b_divider_value_o, rx_gain_db_o}, {13'h3, 5'h3});
        wr(24'h0ff3c0); // power down, output power off
        chk(control_word_o, 24'h0ff3c0);
        wr(24'he00001); // transmit word, phase select off
        wr({9'h0, 6'h10, 6'h00, 3'b101});
        wr(24'h000000); // power up
        wr({2'b00, 2'b00, 13'h3, 5'h0, 2'b10});
        wr(24'h000003);
        wr({2'b11, 2'b11, 13'h1fff, 5'h1f, 2'b10});
        chk({prescaler_select_o, pump_gain_override_o, feedback_mux_select_o, b_divider_value_o,
            a_divider_value_o}, {4'hf, 13'h1fff, 5'h1f});
        wr(24'hffffe1); // transmit word must not land anywhere
        chk({prescaler_select_o, pump_gain_override_o, feedback_mux_select_o, b_divider_value_o,
            a_divider_value_o}, {4'hf, 13'h1fff, 5'h1f});
        wr({2'b01, 2'b00, 13'h3, 5'h0, 2'b10});
        chk({prescaler_select_o, pump_gain_override_o, feedback_mux_select_o, b_divider_value_o,
            a_divider_value_o}, {4'h4, 13'h3, 5'h0});
        chk(control_word_o, 24'h0);
        wr(24'ha5a5a4);
        chk(control_word_o, 24'ha5a5a4);
        chk(24'(cl_cnt), 24'h3);
        for (int g = 0; g < 8; g++) begin
            wr({16'h0, 1'b0, 2'(g), 3'(g), 2'b11});
            chk({rx_bandwidth_select_o, rx_gain_code_o, rx_gain_db_o},
                {2'(g), 3'(g), 5'(3 * g + 3)});
        end
        wr({9'h0, 6'h10, 6'h02, 3'b101});
        chk({cal_divider_value_o, boost_timeout_value_o}, {6'h10, 6'h02});
        bl0 = blen;
        wr(24'h000083);
        for (int i = 0; i < 200 && boost_active_o === 1'b1; i++) @(posedge clk_i);
        chk(24'((blen - bl0) >= 26 && (blen - bl0) <= 56), 24'h1);
        wr({15'h0, 6'h00, 3'b101});
        wr(24'h000083);
        repeat (100) @(posedge clk_i);
        chk(boost_active_o, 24'h1);
        wr(24'h000003);
        chk(boost_active_o, 24'h0);
        wrap_up();
    end
endmodule
bind rfcl_latch_bank rfcl_latch_bank_props rfcl_latch_bank_props_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .load_strobe_pin_i(load_strobe_pin_i),
    .cal_ref_clock_i(cal_ref_clock_i), .prescaler_select_o(prescaler_select_o),
    .b_divider_value_o(b_divider_value_o), .a_divider_value_o(a_divider_value_o),
    .boost_active_o(boost_active_o), .rx_bandwidth_select_o(rx_bandwidth_select_o),
    .rx_gain_code_o(rx_gain_code_o), .rx_gain_db_o(rx_gain_db_o),
    .boost_timeout_value_o(boost_timeout_value_o), .control_word_o(control_word_o),
    .control_load_o(control_load_o));
